// ===== shunt_power_params.svh
// Functional notes
// - Shunt full-scale is 40 mV, widened by gain divider x2, x4, x8 up to 320 mV.
// - Bus voltage range selects exactly 16 V or 32 V full-scale.
// - Gain divider setting divide-by-two gives an 80 mV shunt full-scale.
// - Shunt and bus resolution/averaging settings are independent fields.
// - Current and power results stay zero while calibration is unprogrammed.
// - With calibration set, current (04h) and power (03h) refresh per measurement.
// - Current equals shunt word times calibration, divided by 4096.
// - Power equals current result times bus voltage value, divided by 5000.
// - Bus word left-aligned; lowest data bit at bit three; count is 4 mV.
// - One shunt word count equals 10 microvolts.
// - Power count weight is fixed at 20 times the current step.
// - Conversion ready sets after conversions, averaging and, unless calibration is zero, both products finish.
// - Power-up: 12-bit, divide-by-eight gain, 32 V range, continuous both.
`ifndef SHUNT_POWER_PARAMS_SVH
`define SHUNT_POWER_PARAMS_SVH

// Register indices, byte address is four times the index
`define REG_CONFIG_IDX     6'h00
`define REG_SHUNT_IDX      6'h01
`define REG_BUS_IDX        6'h02
`define REG_POWER_IDX      6'h03
`define REG_CURRENT_IDX    6'h04
`define REG_CAL_IDX        6'h05
`define REG_STATUS_IDX     6'h06
`define REG_IRQ_STATUS_IDX 6'h07
`define REG_IRQ_MASK_IDX   6'h08

// Configuration fields
`define CFG_RESET          16'h399f
`define CFG_BUS_RANGE_BIT  13
`define CFG_GAIN_MSB       12
`define CFG_GAIN_LSB       11
`define CFG_BUS_ADC_MSB    10
`define CFG_BUS_ADC_LSB    7
`define CFG_SHUNT_ADC_MSB  6
`define CFG_SHUNT_ADC_LSB  3
`define CFG_MODE_MSB       2
`define CFG_MODE_LSB       0
`define CFG_MODE_CONT_BIT  2
`define CFG_MODE_BUS_BIT   1
`define CFG_MODE_SHUNT_BIT 0

// Scaling constants
`define SHUNT_FS_BASE      17'd4000
`define BUS_FS_16V         13'd4000
`define BUS_FS_32V         13'd8000
`define BUS_WORD_SHIFT     3
`define BUS_CR_BIT         1
`define BUS_OVF_BIT        0
`define CUR_DIVISOR        16'd4096
`define PWR_DIVISOR        16'd5000
`define CUR_MAX_MAG        32'd32767
`define PWR_MAX_MAG        32'd65535
`define CUR_POS_SAT        16'h7fff
`define CUR_NEG_SAT        16'h8000
`define PWR_SAT            16'hffff
`define DIV_LAST_STEP      6'd31
`define FULL_RES_ADC       2'h3

// Interrupt status bits
`define IRQ_CONV_READY_BIT 0
`define IRQ_MATH_OVF_BIT   1

`endif

// ===== shunt_power_pkg.sv
package shunt_power_pkg;

   typedef enum logic [2:0] {
      CALC_IDLE     = 3'b000,
      CALC_CUR_WAIT = 3'b010,
      CALC_PWR_WAIT = 3'b100,
      CALC_DONE     = 3'b101
   } calc_state_e;

   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] cal;
      logic [15:0] shunt_word;
      logic [12:0] bus_counts;
      logic [15:0] current;
      logic [15:0] power;
      logic        conv_ready;
      logic        math_ovf;
      logic        arm_shunt;
      logic        arm_bus;
      logic [22:0] sh_acc;
      logic [7:0]  sh_cnt;
      logic [20:0] bu_acc;
      logic [7:0]  bu_cnt;
      logic        calc_pend;
      calc_state_e state;
      logic        calc_start;
      logic [15:0] op_a;
      logic [15:0] op_b;
      logic [15:0] op_div;
      logic [15:0] rdata;
   } engine_s;

   typedef struct packed {
      logic        busy;
      logic        done;
      logic        neg;
      logic [5:0]  cnt;
      logic [31:0] dvd;
      logic [16:0] rem;
      logic [15:0] dv;
   } divider_s;

   typedef struct packed {
      logic [1:0] status;
      logic [1:0] mask;
   } irq_s;

endpackage : shunt_power_pkg

// ===== mul_div_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "shunt_power_params.svh"
module mul_div_unit (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        start_i,
   input  wire logic [15:0] a_i,
   input  wire logic [15:0] b_i,
   input  wire logic [15:0] divisor_i,
   output logic             done_o,
   output logic             neg_o,
   output logic [31:0]      quot_o
);
   import shunt_power_pkg::*;

   divider_s q, n;
   logic [15:0] a_mag;
   logic [16:0] rem_sh;

   // Signed-magnitude product, then restoring division one bit a cycle
   always_comb begin
      n = q;
      n.done = 1'b0;
      a_mag = a_i[15] ? 16'(-a_i) : a_i;
      rem_sh = {q.rem[15:0], q.dvd[31]};
      if (start_i && !q.busy) begin
         n.neg  = a_i[15];
         n.dvd  = 32'(a_mag) * 32'(b_i);
         n.rem  = 17'h0;
         n.dv   = divisor_i;
         n.cnt  = 6'h0;
         n.busy = 1'b1;
      end else if (q.busy) begin
         // Quotient of the magnitude, so the result truncates toward zero
         if (rem_sh >= {1'b0, q.dv}) begin
            n.rem = 17'(rem_sh - {1'b0, q.dv});
            n.dvd = {q.dvd[30:0], 1'b1};
         end else begin
            n.rem = rem_sh;
            n.dvd = {q.dvd[30:0], 1'b0};
         end
         n.cnt = 6'(q.cnt + 6'h1);
         if (q.cnt == `DIV_LAST_STEP) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign done_o = q.done;
   assign neg_o  = q.neg;
   assign quot_o = q.dvd;

endmodule : mul_div_unit
`default_nettype wire

// ===== irq_unit.sv
`timescale 1ns/1ps
`default_nettype none
module irq_unit (
   input  wire logic       clock_i,
   input  wire logic       resetn_i,
   input  wire logic [1:0] event_i,
   input  wire logic       clear_we_i,
   input  wire logic       mask_we_i,
   input  wire logic [1:0] wdata_i,
   output logic [1:0]      status_o,
   output logic [1:0]      mask_o,
   output logic            irq_o
);
   import shunt_power_pkg::*;

   irq_s q, n;

   // Write one to clear; a new event in the same cycle wins
   always_comb begin
      n = q;
      if (clear_we_i) begin
         n.status = q.status & ~wdata_i;
      end
      n.status = n.status | event_i;
      if (mask_we_i) begin
         n.mask = wdata_i;
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign status_o = q.status;
   assign mask_o   = q.mask;
   assign irq_o    = |(q.status & q.mask);

endmodule : irq_unit
`default_nettype wire

// ===== shunt_power_calc_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "shunt_power_params.svh"
module shunt_power_calc_engine (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   output logic [31:0]      rdata_o,
   input  wire logic [15:0] shunt_sample_i,
   input  wire logic        shunt_valid_i,
   input  wire logic [12:0] bus_sample_i,
   input  wire logic        bus_valid_i,
   output logic             conversion_ready_flag_o,
   output logic             irq_o
);
   import shunt_power_pkg::*;

   engine_s     q, n;
   logic        div_done;
   logic        div_neg;
   logic [31:0] div_quot;
   logic [1:0]  irq_event;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic        irq_clear_we;
   logic        irq_mask_we;

   // Word-aligned register select
   function automatic logic reg_sel(input logic [7:0] a, input logic [5:0] idx);
      reg_sel = (a[1:0] == 2'b00) && (a[7:2] == idx);
   endfunction : reg_sel

   // Filter setting: {low bits dropped, averaging shift}
   function automatic logic [4:0] adc_decode(input logic [3:0] s);
      if (s[3]) begin
         adc_decode = {2'h0, s[2:0]};
      end else begin
         adc_decode = {2'(`FULL_RES_ADC - s[1:0]), 3'h0};
      end
   endfunction : adc_decode

   // Shunt full-scale in 10 uV counts for a gain setting
   function automatic logic [16:0] shunt_limit(input logic [1:0] g);
      shunt_limit = 17'(`SHUNT_FS_BASE << g);
   endfunction : shunt_limit

   // Clear the low bits that a reduced resolution does not keep
   function automatic logic [15:0] drop_low(input logic [15:0] v, input logic [1:0] k);
      drop_low = v & ~16'((16'h1 << k) - 16'h1);
   endfunction : drop_low

   // Clamp a signed shunt sample to the selected full-scale
   function automatic logic [15:0] shunt_clamp(input logic [15:0] s, input logic [16:0] lim);
      if ($signed({s[15], s}) > $signed(lim)) begin
         shunt_clamp = lim[15:0];
      end else if ($signed({s[15], s}) < -$signed(lim)) begin
         shunt_clamp = 16'(-lim);
      end else begin
         shunt_clamp = s;
      end
   endfunction : shunt_clamp

   // Bus word: counts left-aligned above the ready and overflow flags
   function automatic logic [15:0] bus_word(input logic [12:0] c, input logic rdy, input logic ovf);
      bus_word = {3'h0, c} << `BUS_WORD_SHIFT;
      bus_word[`BUS_CR_BIT]  = rdy;
      bus_word[`BUS_OVF_BIT] = ovf;
   endfunction : bus_word

   // Status word: ready flag and math overflow in the low bits
   function automatic logic [15:0] status_word(input logic rdy, input logic ovf);
      status_word = 16'h0;
      status_word[`IRQ_CONV_READY_BIT] = rdy;
      status_word[`IRQ_MATH_OVF_BIT]   = ovf;
   endfunction : status_word

   logic [4:0]  sh_dec;
   logic [4:0]  bu_dec;
   logic [15:0] sh_drop;
   logic [12:0] bu_drop;
   logic [16:0] sh_lim;
   logic [12:0] bu_lim;
   logic [15:0] sh_val;
   logic [12:0] bu_val;
   logic [22:0] sh_sum;
   logic [20:0] bu_sum;
   logic [7:0]  sh_next;
   logic [7:0]  bu_next;
   logic        sh_take;
   logic        bu_take;
   logic [2:0]  mode;
   logic [15:0] cur_res;
   logic        cur_ovf;

   always_comb begin
      n = q;
      n.calc_start = 1'b0;
      irq_event = 2'b00;
      mode = q.cfg[`CFG_MODE_MSB:`CFG_MODE_LSB];
      irq_clear_we = we_i && reg_sel(addr_i, `REG_IRQ_STATUS_IDX);
      irq_mask_we  = we_i && reg_sel(addr_i, `REG_IRQ_MASK_IDX);

      // Separate filter fields for each measurement
      sh_dec = adc_decode(q.cfg[`CFG_SHUNT_ADC_MSB:`CFG_SHUNT_ADC_LSB]);
      bu_dec = adc_decode(q.cfg[`CFG_BUS_ADC_MSB:`CFG_BUS_ADC_LSB]);

      // Gain divider widens the 40 mV base by 2, 4 or 8
      sh_lim = shunt_limit(q.cfg[`CFG_GAIN_MSB:`CFG_GAIN_LSB]);
      // Exactly two bus ranges, 4 mV per count
      bu_lim = q.cfg[`CFG_BUS_RANGE_BIT] ? `BUS_FS_32V : `BUS_FS_16V;

      // Resolution drops low bits, then clamp to the selected full-scale
      sh_drop = drop_low(shunt_sample_i, sh_dec[4:3]);
      bu_drop = 13'(drop_low({3'h0, bus_sample_i}, bu_dec[4:3]));
      sh_val  = shunt_clamp(sh_drop, sh_lim);
      bu_val = (bu_drop > bu_lim) ? bu_lim : bu_drop;

      // Register writes
      if (we_i && reg_sel(addr_i, `REG_CONFIG_IDX)) begin
         n.cfg = wdata_i[15:0];
         n.sh_acc = '0;
         n.sh_cnt = '0;
         n.bu_acc = '0;
         n.bu_cnt = '0;
         // Power-down and ADC-off writes leave the ready flag alone
         if (wdata_i[`CFG_MODE_BUS_BIT:`CFG_MODE_SHUNT_BIT] != 2'b00) begin
            n.conv_ready = 1'b0;
         end
         // Any triggered mode write arms a single shot
         n.arm_shunt = !wdata_i[`CFG_MODE_CONT_BIT] && wdata_i[`CFG_MODE_SHUNT_BIT];
         n.arm_bus   = !wdata_i[`CFG_MODE_CONT_BIT] && wdata_i[`CFG_MODE_BUS_BIT];
      end
      if (we_i && reg_sel(addr_i, `REG_CAL_IDX)) begin
         n.cal = wdata_i[15:0];
         if (wdata_i[15:0] == 16'h0) begin
            n.current = 16'h0;
            n.power   = 16'h0;
         end
      end

      // Register reads, data in the next cycle; status read clears ready
      n.rdata = 16'h0;
      if (re_i) begin
         case (1'b1)
            reg_sel(addr_i, `REG_CONFIG_IDX):     n.rdata = q.cfg;
            reg_sel(addr_i, `REG_SHUNT_IDX):      n.rdata = q.shunt_word;
            reg_sel(addr_i, `REG_BUS_IDX):        n.rdata = bus_word(q.bus_counts, q.conv_ready, q.math_ovf);
            reg_sel(addr_i, `REG_POWER_IDX):      n.rdata = q.power;
            reg_sel(addr_i, `REG_CURRENT_IDX):    n.rdata = q.current;
            reg_sel(addr_i, `REG_CAL_IDX):        n.rdata = q.cal;
            reg_sel(addr_i, `REG_STATUS_IDX):     n.rdata = status_word(q.conv_ready, q.math_ovf);
            reg_sel(addr_i, `REG_IRQ_STATUS_IDX): n.rdata = {14'h0, irq_status};
            reg_sel(addr_i, `REG_IRQ_MASK_IDX):   n.rdata = {14'h0, irq_mask};
            default:                              n.rdata = 16'h0;
         endcase
         if (reg_sel(addr_i, `REG_STATUS_IDX)) begin
            n.conv_ready = 1'b0;
         end
      end

      // Sample acceptance per mode
      sh_take = shunt_valid_i && mode[`CFG_MODE_SHUNT_BIT] && (mode[`CFG_MODE_CONT_BIT] || q.arm_shunt);
      bu_take = bus_valid_i && mode[`CFG_MODE_BUS_BIT] && (mode[`CFG_MODE_CONT_BIT] || q.arm_bus);
      sh_sum  = 23'(q.sh_acc + {{7{sh_val[15]}}, sh_val});
      bu_sum  = 21'(q.bu_acc + {8'h0, bu_val});
      sh_next = 8'(q.sh_cnt + 8'h1);
      bu_next = 8'(q.bu_cnt + 8'h1);

      // Shunt averaging
      if (sh_take) begin
         n.sh_acc = sh_sum;
         n.sh_cnt = sh_next;
         if (sh_next == 8'(8'h1 << sh_dec[2:0])) begin
            n.shunt_word = 16'(sh_sum >>> sh_dec[2:0]);
            n.sh_acc = '0;
            n.sh_cnt = '0;
            n.arm_shunt = 1'b0;
            if (!mode[`CFG_MODE_BUS_BIT]) begin
               n.calc_pend = 1'b1;
            end
         end
      end

      // Bus averaging closes the measurement cycle
      if (bu_take) begin
         n.bu_acc = bu_sum;
         n.bu_cnt = bu_next;
         if (bu_next == 8'(8'h1 << bu_dec[2:0])) begin
            n.bus_counts = 13'(bu_sum >> bu_dec[2:0]);
            n.bu_acc = '0;
            n.bu_cnt = '0;
            n.arm_bus = 1'b0;
            n.calc_pend = 1'b1;
         end
      end

      // Saturate the current quotient into a signed word
      cur_ovf = div_quot > `CUR_MAX_MAG;
      if (cur_ovf) begin
         cur_res = div_neg ? `CUR_NEG_SAT : `CUR_POS_SAT;
      end else begin
         cur_res = div_neg ? 16'(-div_quot[15:0]) : div_quot[15:0];
      end

      // Current and power calculation sequence
      case (q.state)
         CALC_IDLE: begin
            if (q.calc_pend) begin
               n.calc_pend = 1'b0;
               n.math_ovf = 1'b0;
               // Unprogrammed calibration skips both products
               if (n.cal == 16'h0) begin
                  n.current = 16'h0;
                  n.power   = 16'h0;
                  n.state   = CALC_DONE;
               end else begin
                  n.op_a = q.shunt_word;
                  n.op_b = n.cal;
                  n.op_div = `CUR_DIVISOR;
                  n.calc_start = 1'b1;
                  n.state = CALC_CUR_WAIT;
               end
            end
         end
         CALC_CUR_WAIT: begin
            if (div_done) begin
               n.current = (n.cal == 16'h0) ? 16'h0 : cur_res;
               n.math_ovf = cur_ovf;
               // Bus counts in 4 mV steps make power weigh 20 current steps
               n.op_a = cur_res;
               n.op_b = {3'h0, q.bus_counts};
               n.op_div = `PWR_DIVISOR;
               n.calc_start = 1'b1;
               n.state = CALC_PWR_WAIT;
            end
         end
         CALC_PWR_WAIT: begin
            if (div_done) begin
               // A zero calibration written mid-calculation still forces zero
               if (n.cal == 16'h0) begin
                  n.power = 16'h0;
               end else if (div_quot > `PWR_MAX_MAG) begin
                  n.power = `PWR_SAT;
                  n.math_ovf = 1'b1;
               end else begin
                  n.power = div_quot[15:0];
               end
               n.state = CALC_DONE;
            end
         end
         CALC_DONE: begin
            // Ready after both products, or directly with zero calibration; set beats a same-cycle clear
            n.conv_ready = 1'b1;
            irq_event[`IRQ_CONV_READY_BIT] = 1'b1;
            irq_event[`IRQ_MATH_OVF_BIT]   = q.math_ovf;
            n.state = CALC_IDLE;
         end
         default: begin
            n.state = CALC_IDLE;
         end
      endcase
   end

   // State register, power-up defaults
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= '0;
         q.cfg <= `CFG_RESET;
         q.state <= CALC_IDLE;
      end else begin
         q <= n;
      end
   end

   // Shared multiply and truncating divide
   mul_div_unit u_mul_div (
      .clock_i   (clock_i),
      .resetn_i  (resetn_i),
      .start_i   (q.calc_start),
      .a_i       (q.op_a),
      .b_i       (q.op_b),
      .divisor_i (q.op_div),
      .done_o    (div_done),
      .neg_o     (div_neg),
      .quot_o    (div_quot)
   );

   // Sticky event status with mask
   irq_unit u_irq (
      .clock_i    (clock_i),
      .resetn_i   (resetn_i),
      .event_i    (irq_event),
      .clear_we_i (irq_clear_we),
      .mask_we_i  (irq_mask_we),
      .wdata_i    (wdata_i[1:0]),
      .status_o   (irq_status),
      .mask_o     (irq_mask),
      .irq_o      (irq_o)
   );

   assign rdata_o = {16'h0, q.rdata};
   assign conversion_ready_flag_o = q.conv_ready;

endmodule : shunt_power_calc_engine
`default_nettype wire

// ===== power_calc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module power_calc_chk (
   input wire logic        clock_i,
   input wire logic        resetn_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        we_i,
   input wire logic        re_i,
   input wire logic [31:0] rdata_o,
   input wire logic [15:0] shunt_sample_i,
   input wire logic        shunt_valid_i,
   input wire logic [12:0] bus_sample_i,
   input wire logic        bus_valid_i,
   input wire logic        conversion_ready_flag_o,
   input wire logic        irq_o
);
   logic [7:0] idle_q;
   logic [7:0] idle_d;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // Cycles since the last sample, saturating so that old calcs look settled
   always_comb begin
      idle_d = idle_q;
      if (shunt_valid_i || bus_valid_i) idle_d = 8'h00;
      else if (idle_q != 8'hff) idle_d = idle_q + 8'h01;
   end
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) idle_q <= 8'hff;
      else idle_q <= idle_d;
   end
   a_rdata_idle_zero: assert property (!re_i |=> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   a_upper_half_zero: assert property (re_i |=> rdata_o[31:16] == 16'h0)
      else $error("upper half of read data not zero");
   a_unmapped_zero: assert property (re_i && (addr_i[1:0] != 2'b00 || addr_i > 8'h20) |=> rdata_o == 32'h0)
      else $error("unmapped read returned data");
   a_cal_read_back: assert property (we_i && addr_i == 8'h14 ##1 !we_i ##1 re_i && addr_i == 8'h14
      |=> rdata_o[15:0] == $past(wdata_i[15:0], 3)) else $error("calibration read back differs");
   a_ready_after_calc: assert property ($rose(conversion_ready_flag_o) |-> idle_q >= 8'd1 && idle_q < 8'd200)
      else $error("ready flag rose without a recent measurement");
   a_status_read_clear: assert property (re_i && addr_i == 8'h18 && idle_q > 8'd200 |=> !conversion_ready_flag_o)
      else $error("status read did not clear ready flag");
   a_config_write_clear: assert property (we_i && addr_i == 8'h00 && wdata_i[1:0] != 2'b00 && idle_q > 8'd200
      |=> !conversion_ready_flag_o) else $error("config write did not clear ready flag");
   a_irq_fall_write: assert property ($fell(irq_o) |-> $past(we_i))
      else $error("interrupt dropped without a write");
   a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(we_i) || (idle_q >= 8'd1 && idle_q < 8'd200))
      else $error("interrupt rose without a cause");
   c_ready: cover property ($rose(conversion_ready_flag_o));
   c_irq: cover property ($rose(irq_o));
   c_unmapped: cover property (re_i && addr_i > 8'h20);
endmodule : power_calc_chk
bind shunt_power_calc_engine power_calc_chk u_chk (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .shunt_sample_i(shunt_sample_i),
   .shunt_valid_i(shunt_valid_i), .bus_sample_i(bus_sample_i), .bus_valid_i(bus_valid_i),
   .conversion_ready_flag_o(conversion_ready_flag_o), .irq_o(irq_o));
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        clock_i,
   output logic [7:0]       addr_o,
   output logic [31:0]      wdata_o,
   output logic             we_o,
   output logic             re_o,
   input  wire logic [31:0] rdata_i
);
   // Idle bus at time zero
   initial begin
      addr_o = 8'h00;
      wdata_o = 32'h0;
      we_o = 1'b0;
      re_o = 1'b0;
   end
   // One-cycle write strobe beside address and data
   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      we_o <= 1'b1;
      addr_o <= a;
      wdata_o <= {16'h0000, d};
      @(posedge clock_i);
      we_o <= 1'b0;
      wdata_o <= ~{16'h0000, d};
   endtask : reg_write
   // Data is taken at the edge after the read edge
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      re_o <= 1'b1;
      addr_o <= a;
      @(posedge clock_i);
      re_o <= 1'b0;
      @(posedge clock_i);
      d = rdata_i;
   endtask : reg_read
   // Smallest current step in microamps for a peak current
   function automatic int step_for(input int imax_ua);
      return (imax_ua + 32767) / 32768;
   endfunction : step_for
   // Fixed scale constant expressed for microamps and milliohms
   function automatic int cal_value(input int step_ua, input int shunt_mohm);
      return 40960000 / (step_ua * shunt_mohm);
   endfunction : cal_value
   // System trim from a measured against a reported current
   function automatic int cal_trim(input int cal, input int meas, input int rep);
      return cal * meas / rep;
   endfunction : cal_trim
endmodule : host_model
`default_nettype wire

// ===== tb_shunt_power_calc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_shunt_power_calc_engine;
   logic        clock_i;
   logic        resetn_i;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        we;
   logic        re;
   logic [31:0] rdata;
   logic [15:0] shunt_sample;
   logic        shunt_valid;
   logic [12:0] bus_sample;
   logic        bus_valid;
   logic        ready;
   logic        irq;
   logic [31:0] rd;
   int          cal;
   int          errors;
   int          n_compared;
   shunt_power_calc_engine dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
      .we_i(we), .re_i(re), .rdata_o(rdata), .shunt_sample_i(shunt_sample), .shunt_valid_i(shunt_valid),
      .bus_sample_i(bus_sample), .bus_valid_i(bus_valid), .conversion_ready_flag_o(ready), .irq_o(irq));
   host_model u_host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .we_o(we), .re_o(re), .rdata_i(rdata));
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      u_host.reg_read(a, rd);
      check(rd, exp);
   endtask : rd_chk
   // Shunt pulse, then bus pulse; lines scrambled once released
   task automatic push(input logic [15:0] s, input logic [12:0] b, input logic with_bus);
      @(posedge clock_i);
      shunt_sample <= s;
      shunt_valid <= 1'b1;
      @(posedge clock_i);
      shunt_valid <= 1'b0;
      shunt_sample <= ~s;
      bus_sample <= b;
      bus_valid <= with_bus;
      @(posedge clock_i);
      bus_valid <= 1'b0;
      bus_sample <= ~b;
   endtask : push
   task automatic wait_ready();
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 300) begin
         @(posedge clock_i);
         k++;
      end
      check(ready, 32'h1);
   endtask : wait_ready
   // Full calibrated measurement with expectations from the equations
   task automatic measure(input logic [15:0] s, input logic [12:0] b, input int c);
      int cur;
      int pw;
      cur = $signed(s) * c / 4096;
      pw = (cur < 0 ? -cur : cur) * int'(b) / 5000;
      u_host.reg_write(8'h14, c[15:0]);
      push(s, b, 1'b1);
      if (c != 0) begin
         repeat (20) @(posedge clock_i);
         check(ready, 32'h0);
      end
      wait_ready();
      rd_chk(8'h04, {16'h0, s});
      rd_chk(8'h08, {16'h0, b, 3'b010});
      rd_chk(8'h10, {16'h0, cur[15:0]});
      rd_chk(8'h0c, {16'h0, pw[15:0]});
      rd_chk(8'h18, 32'h1);
   endtask : measure
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge clock_i);
      errors++;
      finish_test();
   end
   // Main sequence
   initial begin
      resetn_i = 1'b0;
      shunt_sample = 16'h0;
      shunt_valid = 1'b0;
      bus_sample = 13'h0;
      bus_valid = 1'b0;
      errors = 0;
      n_compared = 0;
      repeat (4) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd_chk(8'h00, 32'h399f);
      rd_chk(8'h10, 32'h0);
      rd_chk(8'h0c, 32'h0);
      measure(16'd1000, 13'd3000, 0);
      for (int g = 0; g < 4; g++) begin
         u_host.reg_write(8'h00, {2'b00, g[0], g[1:0], 8'h33, 3'b111});
         push(16'h7fff, 13'h1fff, 1'b1);
         wait_ready();
         rd_chk(8'h04, 32'd4000 << g);
         rd_chk(8'h08, (g[0] ? 32'd8000 : 32'd4000) << 3 | 32'h2);
         rd_chk(8'h18, 32'h1);
      end
      // Shunt averages two samples while bus takes one
      u_host.reg_write(8'h00, 16'h39cf);
      push(16'd100, 13'd0, 1'b0);
      push(16'd201, 13'd50, 1'b1);
      wait_ready();
      rd_chk(8'h04, 32'd150);
      rd_chk(8'h08, 32'h192);
      rd_chk(8'h18, 32'h1);
      u_host.reg_write(8'h00, 16'h399f);
      cal = u_host.cal_value(u_host.step_for(32768000), 10);
      u_host.reg_write(8'h14, cal[15:0]);
      rd_chk(8'h14, 32'd4096);
      measure(16'd1000, 13'd3000, cal);
      measure(16'hfc18, 13'd2500, 6144);
      measure(16'hfff9, 13'd5000, 1000);
      measure(16'd1000, 13'd3000, u_host.cal_trim(cal, 1100, 1000));
      // Interrupt raised, cleared, then masked
      u_host.reg_write(8'h20, 16'h0001);
      measure(16'd500, 13'd100, 4096);
      check(irq, 32'h1);
      rd_chk(8'h1c, 32'h1);
      u_host.reg_write(8'h1c, 16'h0001);
      @(posedge clock_i);
      check(irq, 32'h0);
      u_host.reg_write(8'h20, 16'h0000);
      measure(16'd500, 13'd100, 4096);
      check(irq, 32'h0);
      rd_chk(8'h1c, 32'h1);
      // Unmapped, misaligned and read-only accesses
      rd_chk(8'h24, 32'h0);
      rd_chk(8'h12, 32'h0);
      u_host.reg_write(8'h10, 16'hffff);
      rd_chk(8'h10, 32'h1f4);
      // Triggered shunt-only shot at 9-bit resolution; a later pulse is not taken
      u_host.reg_write(8'h00, 16'h3981);
      push(16'd1007, 13'd77, 1'b1);
      wait_ready();
      rd_chk(8'h04, 32'd1000);
      rd_chk(8'h10, 32'd1000);
      rd_chk(8'h0c, 32'd20);
      rd_chk(8'h18, 32'h1);
      push(16'd2000, 13'd77, 1'b1);
      repeat (100) @(posedge clock_i);
      check(ready, 32'h0);
      rd_chk(8'h04, 32'd1000);
      // Saturated current raises math overflow
      u_host.reg_write(8'h14, 16'hffff);
      u_host.reg_write(8'h00, 16'h3981);
      push(16'd32000, 13'd77, 1'b1);
      wait_ready();
      rd_chk(8'h10, 32'h7fff);
      rd_chk(8'h0c, 32'd655);
      rd_chk(8'h18, 32'h3);
      rd_chk(8'h1c, 32'h3);
      u_host.reg_write(8'h14, 16'h0000);
      rd_chk(8'h10, 32'h0);
      rd_chk(8'h0c, 32'h0);
      finish_test();
   end
endmodule : tb_shunt_power_calc_engine
`default_nettype wire
